//--- hw/dtt_dual_timer_timebase.sv
`timescale 1ns/1ps
// Function
// - Two 16-bit down counters, two byte preloads each
// - Enabled counter decrements once per clock pulse
// - Underflow from zero raises timer interrupt
// - Underflow reloads counter from combined preloads
// - Interval between interrupts is preload plus one
// - Reset clears counters; enabling at zero fires
// - First timer counts slow, or fast when fast-only
// - Second timer counts system clock over 1.5
// - Enable register bit 2 gates first timer
// - Enable register bit 1 gates second timer
// - Operation register bit 2 runs first timer
// - Operation register bit 3 runs second timer
// - First timer preloads at 0x03 and 0x04
// - Second timer preloads at 0x05 and 0x06
// - Time base divides slow clock by 2^(select+1)
// - Code zero gives half slow rate, halving onward
// - Bit 4 enables time base; select write-only
// - Time base uses slow clock; first timer too unless fast-only
module dtt_dual_timer_timebase (
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire dtt_pkg::dtt_addr_t paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire dtt_pkg::dtt_data_t pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output dtt_pkg::dtt_data_t prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic slow_clock_pin, // Slow clock pin, asynchronous
  input wire logic fast_clock, // Fast clock pin, asynchronous
  input wire logic fast_only_mode, // System in fast-clock-only mode
  output logic timer_one_irq, // First timer request, gated
  output logic timer_two_irq, // Second timer request, gated
  output logic periodic_tick_irq // Time-base request
);
  import dtt_pkg::*;

  // Channel numbers of the two timers
  localparam int unsigned TIMER_COUNT = 2;
  localparam int unsigned TIMER_ONE = 0;
  localparam int unsigned TIMER_TWO = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic timer_one_irq_enable;
    logic timer_two_irq_enable;
    logic timer_one_run;
    logic timer_two_run;
    logic periodic_tick_enable;
    logic [DTT_SELECT_W-1:0] periodic_tick_select;
    dtt_byte_t timer_one_preload_low;
    dtt_byte_t timer_one_preload_high;
    dtt_byte_t timer_two_preload_low;
    dtt_byte_t timer_two_preload_high;
    logic [DTT_PEND_W-1:0] pending;
    logic [1:0] div_phase;
    logic [DTT_CNT_W-1:0] tick_count;
    dtt_data_t rdata;
    logic err;
  } dtt_main_state_t;

  dtt_main_state_t q;
  dtt_main_state_t d;

  logic slow_pulse;
  logic fast_pulse;
  logic timer_one_pulse;
  logic timer_two_pulse;
  logic timer_one_uf;
  logic timer_two_uf;
  logic [DTT_CNT_W-1:0] timer_one_preload;
  logic [DTT_CNT_W-1:0] timer_two_preload;
  logic [TIMER_COUNT-1:0] timer_run;
  logic [TIMER_COUNT-1:0] timer_pulse;
  logic [TIMER_COUNT-1:0] timer_uf;
  logic [DTT_CNT_W-1:0] timer_preload [TIMER_COUNT];
  logic [DTT_CNT_W-1:0] tick_mask;
  logic tick_event;
  dtt_idx_t idx;
  logic aligned;
  logic mapped;
  logic setup_phase;
  logic write_take;
  dtt_byte_t wbyte;
  dtt_byte_t rbyte;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock pins into the system domain

  dtt_pin_edge u_slow_edge (
    .clk(clk),
    .rst(rst),
    .pin_in(slow_clock_pin),
    .rise_pulse(slow_pulse)
  );

  dtt_pin_edge u_fast_edge (
    .clk(clk),
    .rst(rst),
    .pin_in(fast_clock),
    .rise_pulse(fast_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Timers

  assign timer_one_pulse = fast_only_mode ? fast_pulse : slow_pulse;
  assign timer_two_pulse = (q.div_phase != DTT_DIV_PHASE_LAST);
  assign timer_one_preload = {q.timer_one_preload_high, q.timer_one_preload_low};
  assign timer_two_preload = {q.timer_two_preload_high, q.timer_two_preload_low};

  // Both channels share one counter structure and differ only in run bit, pulse source and preload
  assign timer_run[TIMER_ONE] = q.timer_one_run;
  assign timer_run[TIMER_TWO] = q.timer_two_run;
  assign timer_pulse[TIMER_ONE] = timer_one_pulse;
  assign timer_pulse[TIMER_TWO] = timer_two_pulse;
  assign timer_preload[TIMER_ONE] = timer_one_preload;
  assign timer_preload[TIMER_TWO] = timer_two_preload;
  assign timer_one_uf = timer_uf[TIMER_ONE];
  assign timer_two_uf = timer_uf[TIMER_TWO];

  for (genvar ch = 0; ch < TIMER_COUNT; ch++) begin : g_timer
    dtt_reload_counter #(
      .WIDTH(DTT_CNT_W)
    ) u_timer (
      .clk(clk),
      .rst(rst),
      .run(timer_run[ch]),
      .tick(timer_pulse[ch]),
      .preload(timer_preload[ch]),
      .count(),
      .underflow(timer_uf[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Time base: select k fires every 2^(k+1) slow pulses

  always_comb begin
    tick_mask = ~(DTT_CNT_ALL_ONES << (5'(q.periodic_tick_select) + 5'd1));
    tick_event = q.periodic_tick_enable && slow_pulse
      && ((q.tick_count & tick_mask) == tick_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  always_comb begin
    idx = paddr[DTT_IDX_LSB +: DTT_IDX_W];
    aligned = (paddr[DTT_IDX_LSB-1:0] == '0);
    case (idx)
      DTT_IDX_INTERRUPT_ENABLE_REG,
      DTT_IDX_TIMER_ONE_PRELOAD_LOW,
      DTT_IDX_TIMER_ONE_PRELOAD_HIGH,
      DTT_IDX_TIMER_TWO_PRELOAD_LOW,
      DTT_IDX_TIMER_TWO_PRELOAD_HIGH,
      DTT_IDX_OPERATION_CONTROL_PRIMARY,
      DTT_IDX_OPERATION_CONTROL_SECONDARY,
      DTT_IDX_PENDING_STATUS: begin
        mapped = aligned;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    setup_phase = psel && !penable;
    // Data sits in the low byte, so only lane 0 writes
    write_take = psel && penable && pwrite && mapped && pstrb[0];
    wbyte = pwdata[DTT_REG_W-1:0];
  end

  // Read view; write-only registers and fields read as zero
  always_comb begin
    rbyte = DTT_BYTE_ZERO;
    case (idx)
      DTT_IDX_INTERRUPT_ENABLE_REG: begin
        rbyte[DTT_IER_TIMER_ONE_BIT] = q.timer_one_irq_enable;
        rbyte[DTT_IER_TIMER_TWO_BIT] = q.timer_two_irq_enable;
      end
      DTT_IDX_OPERATION_CONTROL_PRIMARY: begin
        rbyte[DTT_OP1_TIMER_ONE_RUN_BIT] = q.timer_one_run;
        rbyte[DTT_OP1_TIMER_TWO_RUN_BIT] = q.timer_two_run;
      end
      DTT_IDX_OPERATION_CONTROL_SECONDARY: begin
        rbyte[DTT_OP2_TICK_ENABLE_BIT] = q.periodic_tick_enable;
      end
      DTT_IDX_PENDING_STATUS: begin
        rbyte[DTT_PEND_W-1:0] = q.pending;
      end
      default: begin
        rbyte = DTT_BYTE_ZERO;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;

    // Read data and error are captured in the setup cycle
    if (setup_phase) begin
      d.rdata = {{(DTT_DATA_W-DTT_REG_W){1'b0}}, rbyte};
      d.err = !mapped;
    end

    if (write_take) begin
      case (idx)
        DTT_IDX_INTERRUPT_ENABLE_REG: begin
          d.timer_one_irq_enable = wbyte[DTT_IER_TIMER_ONE_BIT];
          d.timer_two_irq_enable = wbyte[DTT_IER_TIMER_TWO_BIT];
        end
        DTT_IDX_TIMER_ONE_PRELOAD_LOW: begin
          d.timer_one_preload_low = wbyte;
        end
        DTT_IDX_TIMER_ONE_PRELOAD_HIGH: begin
          d.timer_one_preload_high = wbyte;
        end
        DTT_IDX_TIMER_TWO_PRELOAD_LOW: begin
          d.timer_two_preload_low = wbyte;
        end
        DTT_IDX_TIMER_TWO_PRELOAD_HIGH: begin
          d.timer_two_preload_high = wbyte;
        end
        DTT_IDX_OPERATION_CONTROL_PRIMARY: begin
          d.timer_one_run = wbyte[DTT_OP1_TIMER_ONE_RUN_BIT];
          d.timer_two_run = wbyte[DTT_OP1_TIMER_TWO_RUN_BIT];
        end
        DTT_IDX_OPERATION_CONTROL_SECONDARY: begin
          d.periodic_tick_enable = wbyte[DTT_OP2_TICK_ENABLE_BIT];
          d.periodic_tick_select = wbyte[DTT_OP2_SELECT_LSB +: DTT_SELECT_W];
        end
        DTT_IDX_PENDING_STATUS: begin
          d.pending = q.pending & ~wbyte[DTT_PEND_W-1:0];
        end
        default: begin
          d.pending = q.pending;
        end
      endcase
    end

    // Hardware set wins over a same-cycle software clear
    if (timer_one_uf) begin
      d.pending[DTT_PEND_TIMER_ONE_BIT] = 1'b1;
    end
    if (timer_two_uf) begin
      d.pending[DTT_PEND_TIMER_TWO_BIT] = 1'b1;
    end
    if (tick_event) begin
      d.pending[DTT_PEND_TICK_BIT] = 1'b1;
    end

    // Three-phase divider, always running
    if (q.div_phase == DTT_DIV_PHASE_LAST) begin
      d.div_phase = DTT_DIV_PHASE_FIRST;
    end else begin
      d.div_phase = q.div_phase + 2'd1;
    end

    // Divider restarts from zero each time the time base is enabled
    if (!q.periodic_tick_enable) begin
      d.tick_count = DTT_CNT_RESET;
    end else if (slow_pulse) begin
      d.tick_count = q.tick_count + DTT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && q.err;
  assign timer_one_irq = q.pending[DTT_PEND_TIMER_ONE_BIT] && q.timer_one_irq_enable;
  assign timer_two_irq = q.pending[DTT_PEND_TIMER_TWO_BIT] && q.timer_two_irq_enable;
  assign periodic_tick_irq = q.pending[DTT_PEND_TICK_BIT];

endmodule

//--- hw/dtt_pkg.sv
package dtt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned DTT_DATA_W = 32;
  localparam int unsigned DTT_ADDR_W = 12;
  localparam int unsigned DTT_IDX_W = 8;
  localparam int unsigned DTT_IDX_LSB = 2;
  localparam int unsigned DTT_REG_W = 8;

  typedef logic [DTT_ADDR_W-1:0] dtt_addr_t;
  typedef logic [DTT_DATA_W-1:0] dtt_data_t;
  typedef logic [DTT_IDX_W-1:0] dtt_idx_t;
  typedef logic [DTT_REG_W-1:0] dtt_byte_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam dtt_idx_t DTT_IDX_INTERRUPT_ENABLE_REG = 8'h02;
  localparam dtt_idx_t DTT_IDX_TIMER_ONE_PRELOAD_LOW = 8'h03;
  localparam dtt_idx_t DTT_IDX_TIMER_ONE_PRELOAD_HIGH = 8'h04;
  localparam dtt_idx_t DTT_IDX_TIMER_TWO_PRELOAD_LOW = 8'h05;
  localparam dtt_idx_t DTT_IDX_TIMER_TWO_PRELOAD_HIGH = 8'h06;
  localparam dtt_idx_t DTT_IDX_OPERATION_CONTROL_PRIMARY = 8'h09;
  localparam dtt_idx_t DTT_IDX_OPERATION_CONTROL_SECONDARY = 8'h0A;
  localparam dtt_idx_t DTT_IDX_PENDING_STATUS = 8'h0B;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned DTT_IER_TIMER_ONE_BIT = 2;
  localparam int unsigned DTT_IER_TIMER_TWO_BIT = 1;
  localparam int unsigned DTT_OP1_TIMER_ONE_RUN_BIT = 2;
  localparam int unsigned DTT_OP1_TIMER_TWO_RUN_BIT = 3;
  localparam int unsigned DTT_OP2_TICK_ENABLE_BIT = 4;
  localparam int unsigned DTT_OP2_SELECT_LSB = 0;
  localparam int unsigned DTT_SELECT_W = 4;
  localparam int unsigned DTT_PEND_TIMER_ONE_BIT = 0;
  localparam int unsigned DTT_PEND_TIMER_TWO_BIT = 1;
  localparam int unsigned DTT_PEND_TICK_BIT = 2;
  localparam int unsigned DTT_PEND_W = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter values and reset values
  localparam int unsigned DTT_CNT_W = 16;
  localparam logic [DTT_CNT_W-1:0] DTT_CNT_RESET = 16'h0000;
  localparam logic [DTT_CNT_W-1:0] DTT_CNT_ALL_ONES = 16'hFFFF;
  localparam dtt_byte_t DTT_BYTE_ZERO = 8'h00;
  localparam dtt_data_t DTT_DATA_ZERO = 32'h0000_0000;

  // System clock over 1.5: three phases, two of them count
  localparam logic [1:0] DTT_DIV_PHASE_FIRST = 2'h0;
  localparam logic [1:0] DTT_DIV_PHASE_LAST = 2'h2;

endpackage

//--- hw/dtt_pin_edge.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a clock pin with a rising-edge pulse behind it
module dtt_pin_edge (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pin_in, // Asynchronous pin level
  output logic rise_pulse // One-cycle pulse per rising edge of the pin
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } dtt_edge_state_t;

  dtt_edge_state_t q;
  dtt_edge_state_t d;

  always_comb begin
    d = q;
    d.meta = pin_in;
    d.sync = q.meta;
    d.last = q.sync;
    // Only the second and third flop feed the edge detector
    d.rise = q.sync & ~q.last;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_pulse = q.rise;

endmodule

//--- hw/dtt_reload_counter.sv
`timescale 1ns/1ps
// Down counter with automatic reload on underflow
module dtt_reload_counter #(
  parameter int unsigned WIDTH = 16 // Counter width
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic run, // Count enable
  input wire logic tick, // One-cycle count pulse
  input wire logic [WIDTH-1:0] preload, // Reload value
  output logic [WIDTH-1:0] count, // Current count
  output logic underflow // One-cycle pulse on step from zero
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic uf;
  } dtt_cnt_state_t;

  dtt_cnt_state_t q;
  dtt_cnt_state_t d;

  always_comb begin
    d = q;
    d.uf = 1'b0;
    if (run && tick) begin
      if (q.cnt == '0) begin
        d.cnt = preload;
        d.uf = 1'b1;
      end else begin
        d.cnt = q.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;
  assign underflow = q.uf;

endmodule

//--- testbench/dtt_properties.sv
`timescale 1ns/1ps
module dtt_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire dtt_pkg::dtt_addr_t paddr, // Address
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire dtt_pkg::dtt_data_t pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire dtt_pkg::dtt_data_t prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic slow_clock_pin, // Slow pin
  input wire logic fast_clock, // Fast pin
  input wire logic fast_only_mode, // Mode
  input wire logic timer_one_irq, // Irq one
  input wire logic timer_two_irq, // Irq two
  input wire logic periodic_tick_irq // Tick irq
);
  import dtt_pkg::*;
  logic [7:0] idx;
  logic acc, rda, wra, mapped;
  logic [7:0] ier_q, op1_q, op2_q;
  assign idx = paddr[9:2];
  assign acc = psel && penable && pready;
  assign mapped = paddr[1:0] == 2'h0 && idx inside {[8'h02:8'h06], [8'h09:8'h0B]};
  assign rda = acc && !pwrite && mapped;
  assign wra = acc && pwrite && pstrb[0] && mapped;
  // Shadow copies of the control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ier_q <= 8'h00;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
    end else if (wra) begin
      if (idx == 8'h02) ier_q <= pwdata[7:0];
      if (idx == 8'h09) op1_q <= pwdata[7:0];
      if (idx == 8'h0A) op2_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  AST_MAP: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  AST_WO: assert property (rda && idx inside {[8'h03:8'h06]} |-> prdata == 32'h0000_0000)
    else $error("preload readable");
  AST_IER: assert property (rda && idx == 8'h02 |-> prdata[2:1] == ier_q[2:1])
    else $error("enable readback wrong");
  AST_OP1: assert property (rda && idx == 8'h09 |-> prdata[3:2] == op1_q[3:2])
    else $error("run bits readback wrong");
  AST_OP2: assert property (rda && idx == 8'h0A |-> prdata[4:0] == {op2_q[4], 4'h0})
    else $error("secondary readback wrong");
  AST_G1: assert property (timer_one_irq |-> ier_q[2] || $past(ier_q[2]))
    else $error("timer one request not gated");
  AST_G2: assert property (timer_two_irq |-> ier_q[1] || $past(ier_q[1]))
    else $error("timer two request not gated");
  AST_RUN2: assert property ($rose(timer_two_irq) && $past(ier_q[1]) && $past(ier_q[1], 2)
    |-> $past(op1_q[3], 2) || $past(op1_q[3], 3) || $past(op1_q[3], 4))
    else $error("timer two fired while stopped");
  AST_TB: assert property ($rose(periodic_tick_irq)
    |-> op2_q[4] || $past(op2_q[4]) || $past(op2_q[4], 2) || $past(op2_q[4], 3))
    else $error("tick while time base off");
  AST_HOLD1: assert property (timer_one_irq && !wra |=> timer_one_irq)
    else $error("timer one request dropped without a write");
  AST_HOLDT: assert property (periodic_tick_irq && !wra |=> periodic_tick_irq)
    else $error("tick request dropped without a write");
  cover property (acc && pslverr);
  cover property ($rose(timer_one_irq));
  cover property ($rose(periodic_tick_irq));
endmodule
bind dtt_dual_timer_timebase dtt_checker u_dtt_checker (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slow_clock_pin(slow_clock_pin), .fast_clock(fast_clock), .fast_only_mode(fast_only_mode),
  .timer_one_irq(timer_one_irq), .timer_two_irq(timer_two_irq),
  .periodic_tick_irq(periodic_tick_irq)
);

//--- testbench/dtt_dual_timer_timebase_bench.sv
`timescale 1ns/1ps
module dtt_dual_timer_timebase_bench;
  import dtt_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic slow_clock_pin = 0, fast_clock = 0, fast_only_mode = 0;
  logic [3:0] pstrb = 4'hF;
  logic timer_one_irq, timer_two_irq, periodic_tick_irq;
  dtt_addr_t paddr = '0;
  dtt_data_t pwdata = '0;
  dtt_data_t prdata;
  int n_errors = 0, checks = 0, cyc = 0, sdiv = 0, fdiv = 0, t0;
  dtt_dual_timer_timebase u_dtt_dual_timer_timebase (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock_pin(slow_clock_pin), .fast_clock(fast_clock), .fast_only_mode(fast_only_mode),
    .timer_one_irq(timer_one_irq), .timer_two_irq(timer_two_irq),
    .periodic_tick_irq(periodic_tick_irq)
  );
  always #4 clk = ~clk;
  // Slow pin period 8 cycles, fast pin period 10 cycles, both free running
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sdiv <= (sdiv == 3) ? 0 : sdiv + 1;
    fdiv <= (fdiv == 4) ? 0 : fdiv + 1;
    if (sdiv == 3) slow_clock_pin <= ~slow_clock_pin;
    if (fdiv == 4) fast_clock <= ~fast_clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check(r, x);
    check(32'(e), 32'(xe));
  endtask
  function automatic logic irqv(input int k);
    return k == 0 ? timer_one_irq : k == 1 ? timer_two_irq : periodic_tick_irq;
  endfunction
  task automatic wait_rise(input int k);
    @(posedge clk);
    while (irqv(k) !== 1'b1) @(posedge clk);
  endtask
  // Rise to rise spacing, with the pending bit cleared in between
  task automatic period(input int k, input int x);
    int t;
    wait_rise(k);
    wr(8'h0B, 8'(1 << k));
    wait_rise(k);
    t = cyc;
    wr(8'h0B, 8'(1 << k));
    wait_rise(k);
    check(32'(cyc - t), 32'(x));
  endtask
  initial begin
    #240000;
    n_errors++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h02, 32'h0, 1'b0);
    rd(8'h09, 32'h0, 1'b0);
    rd(8'h0A, 32'h0, 1'b0);
    rd(8'h03, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(8'h02, 8'hFF);
    rd(8'h02, 32'h6, 1'b0);
    pstrb <= 4'hE;
    wr(8'h02, 8'h00);
    pstrb <= 4'hF;
    rd(8'h02, 32'h6, 1'b0);
    $display("registers done");
    wr(8'h03, 8'h04);
    wr(8'h04, 8'h00);
    wr(8'h02, 8'h04);
    t0 = cyc;
    wr(8'h09, 8'h04);
    wait_rise(0);
    check(32'(cyc - t0 < 20), 32'h1);
    period(0, 40);
    wr(8'h02, 8'h00);
    repeat (60) @(posedge clk);
    check(32'(timer_one_irq), 32'h0);
    wr(8'h02, 8'h04);
    @(posedge clk);
    check(32'(timer_one_irq), 32'h1);
    fast_only_mode <= 1'b1;
    period(0, 50);
    fast_only_mode <= 1'b0;
    $display("timer one done");
    wr(8'h05, 8'h03);
    wr(8'h06, 8'h01);
    wr(8'h02, 8'h06);
    wr(8'h09, 8'h0C);
    rd(8'h09, 32'hC, 1'b0);
    period(1, 390);
    wr(8'h09, 8'h00);
    repeat (10) @(posedge clk);
    wr(8'h0B, 8'h07);
    repeat (400) @(posedge clk);
    rd(8'h0B, 32'h0, 1'b0);
    $display("timer two done");
    for (int s = 0; s < 5; s++) begin
      wr(8'h0A, 8'(16 + s));
      period(2, 16 << s);
    end
    rd(8'h0A, 32'h10, 1'b0);
    wr(8'h0A, 8'h00);
    repeat (10) @(posedge clk);
    wr(8'h0B, 8'h04);
    repeat (300) @(posedge clk);
    check(32'(periodic_tick_irq), 32'h0);
    $display("time base done");
    print_verdict();
  end
endmodule
